// ---- core/cpu_path_pkg.sv ----
package cpu_path_pkg;

  typedef enum logic [4:0] {
    cmd_nop          = 5'h00,
    cmd_set_control  = 5'h01,
    cmd_clear_control = 5'h02,
    cmd_status_load0 = 5'h03,
    cmd_status_load1 = 5'h04,
    cmd_set_pm       = 5'h05,
    cmd_load_operand = 5'h06,
    cmd_mult_signed  = 5'h07,
    cmd_mult_unsigned = 5'h08,
    cmd_load_acc     = 5'h09,
    cmd_add          = 5'h0a,
    cmd_add_no_sx    = 5'h0b,
    cmd_add_product  = 5'h0c,
    cmd_load_product = 5'h0d,
    cmd_bit_test     = 5'h0e,
    cmd_var_bit_test = 5'h0f,
    cmd_aux_compare  = 5'h10,
    cmd_normalize    = 5'h11
  } cmd_type;

  typedef enum logic [1:0] {
    ctl_ovm = 2'h0,
    ctl_sxm = 2'h1,
    ctl_xf  = 2'h2,
    ctl_tc  = 2'h3
  } ctl_type;

  typedef enum logic [1:0] {
    cmp_eq = 2'h0,
    cmp_lt = 2'h1,
    cmp_gt = 2'h2,
    cmp_ne = 2'h3
  } cmp_type;

  localparam logic [1:0] pm_none = 2'h0;
  localparam logic [1:0] pm_left1 = 2'h1;
  localparam logic [1:0] pm_left4 = 2'h2;
  localparam logic [1:0] pm_right6 = 2'h3;

  // status word zero positions
  localparam int st0_ovm_bit = 11;
  localparam int st0_one_bit = 10;
  // status word one positions
  localparam int st1_tc_bit = 11;
  localparam int st1_sxm_bit = 10;
  localparam int st1_xf_bit = 4;
  localparam int st1_pm_lo = 0;
  localparam logic [15:0] st1_ones_mask = 16'h01ec;

  localparam logic rst_ovm = 1'b0;
  localparam logic rst_sxm = 1'b1;
  localparam logic rst_xf = 1'b1;
  localparam logic rst_tc = 1'b0;
  localparam logic [1:0] rst_pm = 2'h0;

  localparam logic [4:0] max_shift = 5'h10;
  localparam logic [31:0] sat_pos = 32'h7fffffff;
  localparam logic [31:0] sat_neg = 32'h80000000;

endpackage : cpu_path_pkg

// ---- core/datapath_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface datapath_if;
  logic [15:0] shift_data;
  logic [4:0] shift_count;
  logic shift_sign;
  logic [31:0] shift_result;
  logic [15:0] mult_a;
  logic [15:0] mult_b;
  logic mult_unsigned;
  logic [31:0] mult_product;
  modport core (output shift_data, shift_count, shift_sign, mult_a, mult_b,
                mult_unsigned, input shift_result, mult_product);
  modport shifter (input shift_data, shift_count, shift_sign,
                   output shift_result);
  modport multiplier (input mult_a, mult_b, mult_unsigned,
                      output mult_product);
endinterface : datapath_if
`default_nettype wire

// ---- core/scaling_shifter.sv ----
`timescale 1ns/10ps
`default_nettype none
module scaling_shifter (
  datapath_if.shifter dp
);
  logic [4:0] count;
  logic [31:0] extended;

  // counts past the top of the range clamp rather than wrap
  assign count = (dp.shift_count > cpu_path_pkg::max_shift) ?
                 cpu_path_pkg::max_shift : dp.shift_count;
  assign extended = {{16{dp.shift_sign & dp.shift_data[15]}},
                     dp.shift_data};
  // pure combinational path, no cycle overhead
  assign dp.shift_result = extended << count;
endmodule : scaling_shifter
`default_nettype wire

// ---- core/multiplier_16x16.sv ----
`timescale 1ns/10ps
`default_nettype none
module multiplier_16x16 (
  datapath_if.multiplier dp
);
  logic signed [16:0] a_ext;
  logic signed [16:0] b_ext;
  logic signed [33:0] full;

  // one extra bit lets the same signed array do unsigned multiplies
  assign a_ext = {~dp.mult_unsigned & dp.mult_a[15], dp.mult_a};
  assign b_ext = {~dp.mult_unsigned & dp.mult_b[15], dp.mult_b};
  assign full = a_ext * b_ext;
  assign dp.mult_product = full[31:0];
endmodule : multiplier_16x16
`default_nettype wire

// ---- core/cpu_status_shift_multiply_path.sv ----
// Functional notes
// - overflow mode 0 wraps accumulator, 1 saturates by overflow direction
// - overflow mode set, cleared by control instructions, loaded by status load
// - product shift mode 00 passes product unshifted
// - mode 01 shifts product left one, zero into bit 0
// - mode 10 shifts product left four, zero filled
// - mode 11 shifts product right six with sign extension
// - shift acts only on the path; product register never altered
// - product mode loaded by set-mode and second status load; reset clears
// - sign-extension mode picks sign or zero fill in scaling shifter
// - add without sign extension always zero-extends operand
// - sign-extension mode set, cleared, loaded by second status load; reset 1
// - bit tests copy tested data bit into test flag
// - aux compare sets test flag when condition holds versus aux zero
// - normalize writes exclusive-or of accumulator top bits to test flag
// - branches may test the flag; second status load writes it
// - external flag drives output pin; set, cleared; reset 1
// - scaling shifter takes 16 bits, yields 32, no added cycle
// - scaling shift left 0 to 16, fill by sign mode
// - shift count from instruction or multiplier operand register
// - 16x16 product in one cycle, signed except unsigned multiply
// - 16-bit operand register and 32-bit product register
// - saturation values 7fffffff positive and 80000000 negative
`timescale 1ns/10ps
`default_nettype none
module cpu_status_shift_multiply_path (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire cpu_path_pkg::cmd_type instr_cmd,
  input wire logic [15:0] instr_field,
  input wire logic [4:0] instr_shift,
  input wire logic shift_from_operand_reg,
  input wire logic [15:0] data_operand,
  input wire logic [15:0] aux_current,
  input wire logic [15:0] aux_zero,
  input wire logic branch_on_clear,
  output logic branch_condition,
  output logic external_flag_pin,
  output logic [15:0] status_word_zero_value,
  output logic [15:0] status_word_one_value,
  output logic [31:0] accumulator_value,
  output logic [31:0] product_register_value,
  output logic [15:0] multiplier_operand_value,
  output logic overflow_event
);

  ////////////////////////////////////////////////////////////////////////
  // state
  logic overflow_saturate_mode_ff;
  logic sign_extension_mode_ff;
  logic test_control_flag_ff;
  logic external_flag_ff;
  logic [1:0] product_shift_mode_ff;
  logic [15:0] multiplier_operand_register_ff;
  logic [31:0] product_register_ff;
  logic [31:0] acc_ff;
  logic overflow_event_ff;

  logic is_cmd;
  logic [1:0] ctl_sel;
  logic [31:0] product_scaler;
  logic [31:0] alu_operand;
  logic [31:0] sum;
  logic use_sum;
  logic ovf_pos;
  logic ovf_neg;
  logic [31:0] nxt_acc;
  logic [3:0] bit_index;
  logic tested_bit;
  logic compare_true;
  logic normalize_instruction_xor;

  datapath_if dp ();

  scaling_shifter u_shifter (
    .dp(dp.shifter)
  );

  multiplier_16x16 u_mult (
    .dp(dp.multiplier)
  );

  assign is_cmd = instr_valid;
  assign ctl_sel = instr_field[1:0];

  ////////////////////////////////////////////////////////////////////////
  // scaling shifter and multiplier feeds
  assign dp.shift_data = data_operand;
  // the add without sign extension takes the raw word, no shift
  assign dp.shift_count = (instr_cmd == cpu_path_pkg::cmd_add_no_sx) ? 5'h00 :
                          shift_from_operand_reg ?
                          {1'b0, multiplier_operand_register_ff[3:0]} :
                          instr_shift;
  assign dp.shift_sign = sign_extension_mode_ff &&
                         (instr_cmd != cpu_path_pkg::cmd_add_no_sx);
  assign dp.mult_a = multiplier_operand_register_ff;
  assign dp.mult_b = data_operand;
  assign dp.mult_unsigned = (instr_cmd == cpu_path_pkg::cmd_mult_unsigned);

  ////////////////////////////////////////////////////////////////////////
  // product scaler: read-only view of the product register
  always_comb begin
    unique case (product_shift_mode_ff)
      cpu_path_pkg::pm_none: product_scaler = product_register_ff;
      cpu_path_pkg::pm_left1:
        product_scaler = {product_register_ff[30:0], 1'b0};
      cpu_path_pkg::pm_left4:
        product_scaler = {product_register_ff[27:0], 4'h0};
      cpu_path_pkg::pm_right6:
        product_scaler = {{6{product_register_ff[31]}},
                          product_register_ff[31:6]};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // accumulator arithmetic with overflow handling
  always_comb begin
    alu_operand = dp.shift_result;
    use_sum = 1'b0;
    unique case (instr_cmd)
      cpu_path_pkg::cmd_add_product,
      cpu_path_pkg::cmd_load_product: alu_operand = product_scaler;
      default: alu_operand = dp.shift_result;
    endcase
    if (instr_cmd == cpu_path_pkg::cmd_add ||
        instr_cmd == cpu_path_pkg::cmd_add_no_sx ||
        instr_cmd == cpu_path_pkg::cmd_add_product) begin
      use_sum = 1'b1;
    end
  end

  assign sum = acc_ff + alu_operand;
  assign ovf_pos = use_sum && !acc_ff[31] && !alu_operand[31] && sum[31];
  assign ovf_neg = use_sum && acc_ff[31] && alu_operand[31] && !sum[31];
  assign normalize_instruction_xor = acc_ff[31] ^ acc_ff[30];

  always_comb begin
    nxt_acc = acc_ff;
    unique case (instr_cmd)
      cpu_path_pkg::cmd_load_acc,
      cpu_path_pkg::cmd_load_product: nxt_acc = alu_operand;
      cpu_path_pkg::cmd_add,
      cpu_path_pkg::cmd_add_no_sx,
      cpu_path_pkg::cmd_add_product: begin
        if (overflow_saturate_mode_ff && ovf_pos) begin
          nxt_acc = cpu_path_pkg::sat_pos;
        end else if (overflow_saturate_mode_ff && ovf_neg) begin
          nxt_acc = cpu_path_pkg::sat_neg;
        end else begin
          nxt_acc = sum;
        end
      end
      cpu_path_pkg::cmd_normalize: begin
        // one normalising step; a zero accumulator is left alone
        if (!normalize_instruction_xor && acc_ff != 32'h00000000) begin
          nxt_acc = {acc_ff[30:0], 1'b0};
        end
      end
      default: nxt_acc = acc_ff;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      acc_ff <= 32'h00000000;
    end else if (is_cmd) begin
      acc_ff <= nxt_acc;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      overflow_event_ff <= 1'b0;
    end else begin
      overflow_event_ff <= is_cmd && (ovf_pos || ovf_neg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // multiplier registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      multiplier_operand_register_ff <= 16'h0000;
    end else if (is_cmd && instr_cmd == cpu_path_pkg::cmd_load_operand) begin
      multiplier_operand_register_ff <= data_operand;
    end
  end

  // only a multiply writes the product register, never the scaler
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      product_register_ff <= 32'h00000000;
    end else if (is_cmd && (instr_cmd == cpu_path_pkg::cmd_mult_signed ||
                 instr_cmd == cpu_path_pkg::cmd_mult_unsigned)) begin
      product_register_ff <= dp.mult_product;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode bits
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      overflow_saturate_mode_ff <= cpu_path_pkg::rst_ovm;
    end else if (is_cmd) begin
      if (instr_cmd == cpu_path_pkg::cmd_set_control &&
          ctl_sel == cpu_path_pkg::ctl_ovm) begin
        overflow_saturate_mode_ff <= 1'b1;
      end else if (instr_cmd == cpu_path_pkg::cmd_clear_control &&
                   ctl_sel == cpu_path_pkg::ctl_ovm) begin
        overflow_saturate_mode_ff <= 1'b0;
      end else if (instr_cmd == cpu_path_pkg::cmd_status_load0) begin
        overflow_saturate_mode_ff <=
          data_operand[cpu_path_pkg::st0_ovm_bit];
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sign_extension_mode_ff <= cpu_path_pkg::rst_sxm;
    end else if (is_cmd) begin
      if (instr_cmd == cpu_path_pkg::cmd_set_control &&
          ctl_sel == cpu_path_pkg::ctl_sxm) begin
        sign_extension_mode_ff <= 1'b1;
      end else if (instr_cmd == cpu_path_pkg::cmd_clear_control &&
                   ctl_sel == cpu_path_pkg::ctl_sxm) begin
        sign_extension_mode_ff <= 1'b0;
      end else if (instr_cmd == cpu_path_pkg::cmd_status_load1) begin
        sign_extension_mode_ff <=
          data_operand[cpu_path_pkg::st1_sxm_bit];
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      product_shift_mode_ff <= cpu_path_pkg::rst_pm;
    end else if (is_cmd) begin
      if (instr_cmd == cpu_path_pkg::cmd_set_pm) begin
        product_shift_mode_ff <= instr_field[1:0];
      end else if (instr_cmd == cpu_path_pkg::cmd_status_load1) begin
        product_shift_mode_ff <=
          data_operand[cpu_path_pkg::st1_pm_lo +: 2];
      end
    end
  end

  // pin comes straight from a flop so it cannot glitch
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      external_flag_ff <= cpu_path_pkg::rst_xf;
    end else if (is_cmd) begin
      if (instr_cmd == cpu_path_pkg::cmd_set_control &&
          ctl_sel == cpu_path_pkg::ctl_xf) begin
        external_flag_ff <= 1'b1;
      end else if (instr_cmd == cpu_path_pkg::cmd_clear_control &&
                   ctl_sel == cpu_path_pkg::ctl_xf) begin
        external_flag_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // test/control flag
  // tested bit 0 of the field picks the word's msb
  assign bit_index = (instr_cmd == cpu_path_pkg::cmd_var_bit_test) ?
                     multiplier_operand_register_ff[3:0] : instr_field[3:0];
  assign tested_bit = data_operand[4'hf - bit_index];

  always_comb begin
    unique case (instr_field[1:0])
      cpu_path_pkg::cmp_eq: compare_true = (aux_current == aux_zero);
      cpu_path_pkg::cmp_lt: compare_true = (aux_current < aux_zero);
      cpu_path_pkg::cmp_gt: compare_true = (aux_current > aux_zero);
      cpu_path_pkg::cmp_ne: compare_true = (aux_current != aux_zero);
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      test_control_flag_ff <= cpu_path_pkg::rst_tc;
    end else if (is_cmd) begin
      unique case (instr_cmd)
        cpu_path_pkg::cmd_bit_test,
        cpu_path_pkg::cmd_var_bit_test:
          test_control_flag_ff <= tested_bit;
        cpu_path_pkg::cmd_aux_compare:
          test_control_flag_ff <= compare_true;
        cpu_path_pkg::cmd_normalize:
          test_control_flag_ff <= normalize_instruction_xor;
        cpu_path_pkg::cmd_status_load1:
          test_control_flag_ff <=
            data_operand[cpu_path_pkg::st1_tc_bit];
        cpu_path_pkg::cmd_set_control:
          if (ctl_sel == cpu_path_pkg::ctl_tc) test_control_flag_ff <= 1'b1;
        cpu_path_pkg::cmd_clear_control:
          if (ctl_sel == cpu_path_pkg::ctl_tc) test_control_flag_ff <= 1'b0;
        default: test_control_flag_ff <= test_control_flag_ff;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs; fields held elsewhere read as zero, reserved bits as one
  assign branch_condition = test_control_flag_ff ^ branch_on_clear;
  assign external_flag_pin = external_flag_ff;
  assign status_word_zero_value =
    (16'h0001 << cpu_path_pkg::st0_one_bit) |
    ({15'h0000, overflow_saturate_mode_ff} << cpu_path_pkg::st0_ovm_bit);
  assign status_word_one_value = cpu_path_pkg::st1_ones_mask |
    ({15'h0000, test_control_flag_ff} << cpu_path_pkg::st1_tc_bit) |
    ({15'h0000, sign_extension_mode_ff} << cpu_path_pkg::st1_sxm_bit) |
    ({15'h0000, external_flag_ff} << cpu_path_pkg::st1_xf_bit) |
    ({14'h0000, product_shift_mode_ff} << cpu_path_pkg::st1_pm_lo);
  assign accumulator_value = acc_ff;
  assign product_register_value = product_register_ff;
  assign multiplier_operand_value = multiplier_operand_register_ff;
  assign overflow_event = overflow_event_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence seq_add_cmd;
    is_cmd && use_sum;
  endsequence

  sequence seq_set_xf;
    is_cmd && instr_cmd == cpu_path_pkg::cmd_set_control &&
    ctl_sel == cpu_path_pkg::ctl_xf;
  endsequence

  chk_sat_positive: assert property (
    seq_add_cmd ##0 (overflow_saturate_mode_ff && ovf_pos) |=>
      accumulator_value == 32'h7fffffff)
    else $error("positive overflow did not saturate");

  chk_sat_negative: assert property (
    seq_add_cmd ##0 (overflow_saturate_mode_ff && ovf_neg) |=>
      accumulator_value == 32'h80000000)
    else $error("negative overflow did not saturate");

  chk_wrap_normal: assert property (
    seq_add_cmd ##0 !overflow_saturate_mode_ff |=>
      accumulator_value == $past(acc_ff) + $past(alu_operand))
    else $error("overflow mode off did not wrap");

  chk_product_scaler_view: assert property (
    (product_shift_mode_ff == 2'h0 && product_scaler == product_register_ff) ||
    (product_shift_mode_ff == 2'h1 &&
      product_scaler == (product_register_ff << 1)) ||
    (product_shift_mode_ff == 2'h2 &&
      product_scaler == (product_register_ff << 4)) ||
    (product_shift_mode_ff == 2'h3 &&
      product_scaler == 32'($signed(product_register_ff) >>> 6)))
    else $error("product scaler output wrong");

  chk_product_register_hold: assert property (
    !(is_cmd && (instr_cmd == cpu_path_pkg::cmd_mult_signed ||
      instr_cmd == cpu_path_pkg::cmd_mult_unsigned)) |=>
      $stable(product_register_value))
    else $error("product register changed without multiply");

  chk_mult_signed: assert property (
    is_cmd && instr_cmd == cpu_path_pkg::cmd_mult_signed |=>
      product_register_value == 32'($signed($past(dp.mult_a)) *
                                    $signed($past(data_operand))))
    else $error("signed product wrong");

  chk_pm_load: assert property (
    is_cmd && instr_cmd == cpu_path_pkg::cmd_set_pm |=>
      status_word_one_value[1:0] == $past(instr_field[1:0]))
    else $error("product shift mode not loaded");

  chk_add_no_sign_extend_instruction_zero: assert property (
    is_cmd && instr_cmd == cpu_path_pkg::cmd_add_no_sx && !ovf_pos |=>
      accumulator_value == $past(acc_ff) + {16'h0000, $past(data_operand)})
    else $error("add without sign extension extended the sign");

  chk_bit_test: assert property (
    is_cmd && instr_cmd == cpu_path_pkg::cmd_var_bit_test |=>
      test_control_flag_ff == $past(data_operand[4'hf -
        multiplier_operand_register_ff[3:0]]))
    else $error("bit test flag wrong");

  chk_normalize_instruction_flag: assert property (
    is_cmd && instr_cmd == cpu_path_pkg::cmd_normalize |=>
      test_control_flag_ff == ($past(acc_ff[31]) ^ $past(acc_ff[30])))
    else $error("normalize flag wrong");

  chk_xf_set: assert property (
    seq_set_xf |=> external_flag_pin ##1
      (external_flag_pin || $past(instr_cmd) ==
        cpu_path_pkg::cmd_clear_control))
    else $error("external flag pin not raised");

endmodule : cpu_status_shift_multiply_path
`default_nettype wire

// ---- core/end.sv ----
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ---- tb/instr_source.sv ----
`timescale 1ns/10ps
`default_nettype none
module instr_source (
  input wire logic core_clk,
  output logic instr_valid,
  output cpu_path_pkg::cmd_type instr_cmd,
  output logic [15:0] instr_field,
  output logic [4:0] instr_shift,
  output logic shift_from_operand_reg,
  output logic [15:0] data_operand,
  output logic [15:0] aux_current,
  output logic [15:0] aux_zero,
  output logic branch_on_clear
);
  initial begin
    instr_valid = 1'b0;
    instr_cmd = cpu_path_pkg::cmd_nop;
    instr_field = 16'h0000;
    instr_shift = 5'h00;
    shift_from_operand_reg = 1'b0;
    data_operand = 16'h0000;
    aux_current = 16'h0000;
    aux_zero = 16'h0000;
    branch_on_clear = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  // one command per edge; taken at the edge after it is launched
  task automatic go(input cpu_path_pkg::cmd_type c,
    input logic [15:0] d = 16'h0000, input logic [15:0] f = 16'h0000,
    input logic [4:0] s = 5'h00, input logic o = 1'b0);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_cmd <= c;
    data_operand <= d;
    instr_field <= f;
    instr_shift <= s;
    shift_from_operand_reg <= o;
  endtask : go
  // released bus shows inverted data so stale values never look fresh
  task automatic idle();
    @(posedge core_clk);
    instr_valid <= 1'b0;
    data_operand <= ~data_operand;
    instr_field <= ~instr_field;
  endtask : idle
  // aux words and branch polarity change only on a clock edge
  task automatic aux(input logic [15:0] a, input logic [15:0] z,
    input logic b);
    @(posedge core_clk);
    aux_current <= a;
    aux_zero <= z;
    branch_on_clear <= b;
  endtask : aux
endmodule : instr_source
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic core_clk, resetn, instr_valid, shift_from_operand_reg;
  logic branch_on_clear, branch_condition, external_flag_pin;
  logic overflow_event;
  cpu_path_pkg::cmd_type instr_cmd;
  logic [15:0] instr_field, data_operand, aux_current, aux_zero;
  logic [4:0] instr_shift;
  logic [15:0] status_word_zero_value, status_word_one_value;
  logic [15:0] multiplier_operand_value;
  logic [31:0] accumulator_value, product_register_value;
  int err_total, compares;
  instr_source src (.core_clk, .instr_valid, .instr_cmd, .instr_field,
    .instr_shift, .shift_from_operand_reg, .data_operand, .aux_current,
    .aux_zero, .branch_on_clear);
  cpu_status_shift_multiply_path uut (.core_clk, .resetn, .instr_valid,
    .instr_cmd, .instr_field, .instr_shift, .shift_from_operand_reg,
    .data_operand, .aux_current, .aux_zero, .branch_on_clear,
    .branch_condition, .external_flag_pin, .status_word_zero_value,
    .status_word_one_value, .accumulator_value, .product_register_value,
    .multiplier_operand_value, .overflow_event);
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s,
    input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // last command is taken at this edge; look once its updates land
  task automatic done();
    src.idle();
    #1;
  endtask : done
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("st0", 32'(status_word_zero_value), 32'h0400);
    chk("st1", 32'(status_word_one_value), 32'h05fc);
    chk("xf pin", 32'(external_flag_pin), 32'h1);
    $display("reset test finished");
  endtask : t_reset
  task automatic t_pm();
    // -16 * 291 as a signed product
    logic [31:0] p = 32'hffffedd0;
    logic [31:0] e [4];
    e[0] = p;
    e[1] = p << 1;
    e[2] = p << 4;
    e[3] = $signed(p) >>> 6;
    src.go(cpu_path_pkg::cmd_load_operand, 16'hfff0);
    src.go(cpu_path_pkg::cmd_mult_signed, 16'h0123);
    for (int m = 0; m < 4; m++) begin
      src.go(cpu_path_pkg::cmd_set_pm, 16'h0000, 16'(m));
      src.go(cpu_path_pkg::cmd_load_product);
      done();
      chk("product_scaler", accumulator_value, e[m]);
      chk("product_register", product_register_value, p);
    end
    chk("st1 pm", 32'(status_word_one_value), 32'h05ff);
    src.go(cpu_path_pkg::cmd_mult_unsigned, 16'h0123);
    done();
    chk("product_register u", product_register_value, 32'h0122edd0);
    chk("multiplier_operand_register", 32'(multiplier_operand_value), 32'hfff0);
    $display("product test finished");
  endtask : t_pm
  task automatic t_shift();
    src.go(cpu_path_pkg::cmd_load_acc, 16'h8001, 16'h0000, 5'h04);
    done();
    chk("sx on", accumulator_value, 32'hfff80010);
    src.go(cpu_path_pkg::cmd_clear_control, 16'h0000, 16'h0001);
    src.go(cpu_path_pkg::cmd_load_acc, 16'h8001, 16'h0000, 5'h04);
    done();
    chk("sx off", accumulator_value, 32'h00080010);
    src.go(cpu_path_pkg::cmd_load_operand, 16'h000f);
    src.go(cpu_path_pkg::cmd_load_acc, 16'h0001, 16'h0000, 5'h00, 1'b1);
    done();
    chk("multiplier_operand_register shift", accumulator_value, 32'h00008000);
    src.go(cpu_path_pkg::cmd_load_acc, 16'h0001, 16'h0000, 5'h10);
    done();
    chk("shift 16", accumulator_value, 32'h00010000);
    src.go(cpu_path_pkg::cmd_set_control, 16'h0000, 16'h0001);
    src.go(cpu_path_pkg::cmd_load_acc);
    src.go(cpu_path_pkg::cmd_add_no_sx, 16'h8000);
    done();
    chk("add_no_sign_extend_instruction", accumulator_value, 32'h00008000);
    $display("shifter test finished");
  endtask : t_shift
  task automatic t_sat();
    src.go(cpu_path_pkg::cmd_load_acc, 16'h7fff, 16'h0000, 5'h10);
    src.go(cpu_path_pkg::cmd_add, 16'h7fff, 16'h0000, 5'h10);
    done();
    chk("wrap", accumulator_value, 32'hfffe0000);
    chk("ovf", 32'(overflow_event), 32'h1);
    src.go(cpu_path_pkg::cmd_set_control);
    src.go(cpu_path_pkg::cmd_load_acc, 16'h7fff, 16'h0000, 5'h10);
    src.go(cpu_path_pkg::cmd_add, 16'h7fff, 16'h0000, 5'h10);
    done();
    chk("sat pos", accumulator_value, 32'h7fffffff);
    chk("st0 ovm", 32'(status_word_zero_value), 32'h0c00);
    src.go(cpu_path_pkg::cmd_load_acc, 16'h8000, 16'h0000, 5'h10);
    src.go(cpu_path_pkg::cmd_add, 16'h8000, 16'h0000, 5'h10);
    src.go(cpu_path_pkg::cmd_status_load0, 16'hf7ff);
    done();
    chk("sat neg", accumulator_value, 32'h80000000);
    chk("st0 load", 32'(status_word_zero_value), 32'h0400);
    $display("saturation test finished");
  endtask : t_sat
  task automatic t_flags();
    src.go(cpu_path_pkg::cmd_bit_test, 16'h8000);
    done();
    chk("bit 1", 32'(branch_condition), 32'h1);
    src.go(cpu_path_pkg::cmd_load_operand);
    src.go(cpu_path_pkg::cmd_var_bit_test, 16'h7fff);
    done();
    chk("variable_bit_test_instruction 0", 32'(branch_condition), 32'h0);
    src.aux(16'h0001, 16'h0002, 1'b0);
    src.go(cpu_path_pkg::cmd_aux_compare, 16'h0000, 16'h0001);
    done();
    chk("cmp lt", 32'(branch_condition), 32'h1);
    src.go(cpu_path_pkg::cmd_aux_compare);
    done();
    chk("cmp eq", 32'(branch_condition), 32'h0);
    src.aux(16'h0003, 16'h0002, 1'b0);
    src.go(cpu_path_pkg::cmd_aux_compare, 16'h0000, 16'h0002);
    done();
    chk("cmp gt", 32'(branch_condition), 32'h1);
    src.go(cpu_path_pkg::cmd_load_acc, 16'h2000, 16'h0000, 5'h10);
    src.go(cpu_path_pkg::cmd_normalize);
    done();
    chk("normalize_instruction", 32'(branch_condition), 32'h0);
    // bit 4 set in the load data: the pin must not follow it
    src.go(cpu_path_pkg::cmd_status_load1, 16'h0811);
    src.go(cpu_path_pkg::cmd_clear_control, 16'h0000, 16'h0002);
    done();
    chk("st1 load", 32'(status_word_one_value), 32'h09ed);
    chk("xf clr", 32'(external_flag_pin), 32'h0);
    src.go(cpu_path_pkg::cmd_set_control, 16'h0000, 16'h0002);
    done();
    chk("xf set", 32'(external_flag_pin), 32'h1);
    src.aux(16'h0001, 16'h0002, 1'b1);
    src.go(cpu_path_pkg::cmd_aux_compare, 16'h0000, 16'h0003);
    done();
    chk("cmp ne inv", 32'(branch_condition), 32'h0);
    $display("flag test finished");
  endtask : t_flags
  //////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    $display("FAIL timeout expected 0 seen 1");
    summarize();
  end
  initial begin
    resetn = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    #1;
    t_reset();
    t_pm();
    t_shift();
    t_sat();
    t_flags();
    summarize();
  end
endmodule : tb
`default_nettype wire
